// ==== test_tft_panel_timing_and_touch_port.sv ====
// self-checking bench for the panel timing and touch port
`timescale 1ns/1ps
module test_tft_panel_timing_and_touch_port;
  import tft_pkg::*;
  localparam logic [11:0] X_EXP = 12'habc;
  localparam logic [11:0] Y_EXP = 12'h5a3;
  logic ref_clk_i = 1'b0;
  logic touch_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  rgb_t pixel_colour_i = 18'h2a5c3;
  logic backlight_en_i = 1'b0;
  logic touch_read_i = 1'b0;
  logic pen_down_irq_n_i = 1'b1;
  logic sdo, busy, en, bl, req, fs, cs_n, sclk, sdi, pdn, pev, pend, done;
  logic pclk, busy_q;
  logic busy_seen = 1'b0;
  rgb_t rgb;
  logic [10:0] x;
  logic [9:0] y;
  touch_sample_t smp;
  logic [15:0] cmds;
  int n_errors = 0;
  int checks_done = 0;
  int n_done = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  initial
  begin
    #4;
    forever #7.5 touch_clk_i = ~touch_clk_i;
  end
  always @(negedge ref_clk_i)
    if (done === 1'b1)
      n_done++;
  always @(negedge ref_clk_i)
    if (busy_q === 1'b1)
      busy_seen = 1'b1;
  tft_panel_timing_and_touch_port uut (
    .ref_clk_i, .arst_n_i, .touch_clk_i, .pixel_colour_i, .backlight_en_i, .touch_read_i,
    .digitizer_sdo_i(sdo), .digitizer_busy_i(busy), .pen_down_irq_n_i,
    .panel_pixel_clock_o(pclk), .pixel_data_enable_o(en), .panel_rgb_o(rgb), .backlight_on_o(bl),
    .pixel_req_o(req), .pixel_x_o(x), .pixel_y_o(y), .frame_start_o(fs),
    .digitizer_cs_n_o(cs_n), .digitizer_serial_clock_o(sclk), .digitizer_sdi_o(sdi),
    .digitizer_busy_o(busy_q), .pen_down_o(pdn), .pen_event_o(pev), .touch_pending_o(pend),
    .touch_sample_o(smp), .touch_done_o(done)
  );
  touch_digitizer_model #(.X_VAL(X_EXP), .Y_VAL(Y_EXP)) dig (
    .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .busy_o(busy), .cmd_hist_o(cmds)
  );
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic t_panel();
    rgb_t exp;
    int hi;
    hi = 0;
    @(posedge ref_clk_i);
    #1;
    chk("origin", 24'h000003, {1'b0, x, y, fs, req});
    chk("panel clock low", 24'h000000, {23'h000000, pclk});
    for (int i = 2; i < 1058; i++)
    begin
      @(posedge ref_clk_i);
      exp = pixel_colour_i;
      pixel_colour_i <= rgb_t'(18'(i * 18'h00b5d));
      #1;
      hi += int'(en === 1'b1);
      chk("colour", (en === 1'b1) ? 24'(exp) : 24'h000000, 24'(rgb));
    end
    chk("enable cycles", 24'h000320, 24'(hi));
    @(posedge ref_clk_i);
    #1;
    chk("next line", 24'h000003, {13'h0000, y, en});
    @(negedge ref_clk_i);
    #1;
    chk("panel clock high", 24'h000001, {23'h000000, pclk});
    $display("panel test done");
  endtask : t_panel
  task automatic t_backlight();
    for (int v = 1; v >= 0; v--)
    begin
      @(posedge ref_clk_i);
      backlight_en_i <= v[0];
      @(posedge ref_clk_i);
      #1;
      chk("backlight", 24'(v), {23'h000000, bl});
    end
    $display("backlight test done");
  endtask : t_backlight
  task automatic t_pen();
    int seen;
    seen = 0;
    @(posedge ref_clk_i);
    pen_down_irq_n_i <= 1'b0;
    repeat (8)
    begin
      @(posedge ref_clk_i);
      #1;
      seen += int'(pev === 1'b1);
    end
    chk("pen event", 24'h000001, 24'(seen));
    chk("pen level", 24'h000001, {23'h000000, pdn});
    @(posedge ref_clk_i);
    pen_down_irq_n_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk("pen released", 24'h000000, {23'h000000, pdn});
    $display("pen test done");
  endtask : t_pen
  task automatic t_touch();
    @(posedge ref_clk_i);
    touch_read_i <= 1'b1;
    @(posedge ref_clk_i);
    touch_read_i <= 1'b0;
    #1;
    chk("pending", 24'h000001, {23'h000000, pend});
    repeat (4) @(posedge ref_clk_i);
    // second request lands while the first is in flight
    touch_read_i <= 1'b1;
    @(posedge ref_clk_i);
    touch_read_i <= 1'b0;
    for (int k = 0; k < 3000 && n_done == 0; k++)
      @(posedge ref_clk_i);
    if (n_done == 0)
      chk("read finished", 24'h000001, 24'h000000);
    else
    begin
      #1;
      chk("sample", {X_EXP, Y_EXP}, smp);
      chk("commands", 24'h00d090, {8'h00, cmds});
      chk("pending cleared", 24'h000000, {23'h000000, pend});
      chk("busy seen", 24'h000001, {23'h000000, busy_seen});
      repeat (1500) @(posedge ref_clk_i);
      chk("reads done", 24'h000001, 24'(n_done));
    end
    $display("touch test done");
  endtask : t_touch
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    t_panel();
    t_backlight();
    t_pen();
    t_touch();
    results();
  end
endmodule : test_tft_panel_timing_and_touch_port

// ==== tft_panel_timing_and_touch_port.sv ====
// 800x600 tft panel timing generator with touch digitizer port
//
// Overview of operation
// R01: panel pixel clock runs near 39.79 MHz, 25.13 ns; timing counts these clocks.
// R02: panel clock high time stays within 40 to 60 percent, nominal 50.
// R03: line period between enable rising edges lasts at least 1000, typically 1056 clocks.
// R04: data enable stays high 800 clocks per active line.
// R05: vertical blanking of 10 to 110 lines, typically 28, with enable low.
// R06: each frame holds 600 active lines, each with its own enable pulse.
// R07: colour is an 18-bit bus of three six-bit fields, bit 0 least significant.
// R08: a separate output switches the backlight, independent of pixel timing.
// R09: digitizer converts touch x and y to 12-bit values read over serial port.
// R10: device drives chip select low, serial clock, data; receives data, busy, pen irq.
// R11: colour only meaningful while enable high; counters start at first active pixel.
// R12: pen-down input synchronised and reported as an event to start a read.
`timescale 1ns/1ps
module tft_panel_timing_and_touch_port
  import tft_pkg::*;
(
  input wire logic ref_clk_i, // pixel-rate clock, 40 MHz
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic touch_clk_i, // link clock of the digitizer serial port
  input rgb_t pixel_colour_i, // colour for pixel_x_o/pixel_y_o, same cycle
  input wire logic backlight_en_i, // backlight request, ref domain
  input wire logic touch_read_i, // pulse: read x and y from digitizer
  input wire logic digitizer_sdo_i, // digitizer serial data out (pin)
  input wire logic digitizer_busy_i, // digitizer conversion busy (pin)
  input wire logic pen_down_irq_n_i, // digitizer pen-down interrupt, active low (pin)
  output logic panel_pixel_clock_o, // panel clock
  output logic pixel_data_enable_o, // data enable to panel
  output rgb_t panel_rgb_o, // 18-bit colour bus
  output logic backlight_on_o, // backlight enable
  output logic pixel_req_o, // colour wanted for current position
  output logic [10:0] pixel_x_o, // current column
  output logic [9:0] pixel_y_o, // current line
  output logic frame_start_o, // pulse at first pixel of a frame
  output logic digitizer_cs_n_o, // digitizer chip select, active low
  output logic digitizer_serial_clock_o, // digitizer serial clock
  output logic digitizer_sdi_o, // digitizer serial data in
  output logic digitizer_busy_o, // synchronised busy level
  output logic pen_down_o, // synchronised pen-down level
  output logic pen_event_o, // pulse when the pen touches
  output logic touch_pending_o, // a read is in flight
  output touch_sample_t touch_sample_o, // last x and y read
  output logic touch_done_o // pulse when touch_sample_o updates
);

  // ---------------------------------------------------------------
  // panel clock
  // ---------------------------------------------------------------
  // a flop can only make half the ref rate, so the panel clock is the
  // inverted ref clock: exactly 50 percent duty, and data launched on
  // the ref rising edge is sampled half a period later by the panel
  assign panel_pixel_clock_o = ~ref_clk_i; // see R01 see R02

  // ---------------------------------------------------------------
  // position counters
  // ---------------------------------------------------------------
  logic [10:0] h_cnt;
  logic [9:0] v_cnt;
  logic line_end;
  logic in_active;

  assign line_end = (h_cnt == LINE_TOTAL - 11'h001);
  assign in_active = (h_cnt < LINE_ACTIVE_WIDTH) && (v_cnt < FRAME_ACTIVE_LINES);

  // reset puts both counters on the first active pixel
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      h_cnt <= 11'h000; // see R11
      v_cnt <= 10'h000;
    end
    else
    begin
      h_cnt <= line_end ? 11'h000 : h_cnt + 11'h001; // see R03
      if (line_end)
        v_cnt <= (v_cnt == FRAME_TOTAL_LINES - 10'h001) ? 10'h000 : v_cnt + 10'h001; // see R05 see R06
    end
  end

  // ---------------------------------------------------------------
  // request stage and panel stage
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pixel_req_o <= 1'b0;
      pixel_x_o <= 11'h000;
      pixel_y_o <= 10'h000;
      frame_start_o <= 1'b0;
    end
    else
    begin
      pixel_req_o <= in_active; // see R04
      pixel_x_o <= h_cnt;
      pixel_y_o <= v_cnt;
      frame_start_o <= (h_cnt == 11'h000) && (v_cnt == 10'h000);
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pixel_data_enable_o <= 1'b0;
      panel_rgb_o <= '0;
    end
    else
    begin
      pixel_data_enable_o <= pixel_req_o; // see R04 see R05 see R06
      // blank colour outside the window keeps the bus quiet
      panel_rgb_o <= pixel_req_o ? pixel_colour_i : '0; // see R07 see R11
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      backlight_on_o <= 1'b0;
    else
      backlight_on_o <= backlight_en_i; // see R08
  end

  // ---------------------------------------------------------------
  // digitizer pin inputs
  // ---------------------------------------------------------------
  logic pen_meta;
  logic pen_sync;
  logic pen_prev;
  logic busy_meta;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      // all three stages rest at the pin's idle level so no false press follows reset
      pen_meta <= 1'b1;
      pen_sync <= 1'b1;
      pen_prev <= 1'b1;
      busy_meta <= 1'b0;
      digitizer_busy_o <= 1'b0;
      pen_down_o <= 1'b0;
      pen_event_o <= 1'b0;
    end
    else
    begin
      pen_meta <= pen_down_irq_n_i;
      pen_sync <= pen_meta;
      pen_prev <= pen_sync;
      busy_meta <= digitizer_busy_i;
      digitizer_busy_o <= busy_meta; // see R10
      pen_down_o <= ~pen_sync; // see R12
      pen_event_o <= pen_prev & ~pen_sync; // see R12
    end
  end

  // ---------------------------------------------------------------
  // read handshake with the link domain
  // ---------------------------------------------------------------
  logic start_tgl;
  logic done_tgl;
  logic done_meta;
  logic done_sync;
  logic done_seen;
  touch_sample_t eng_sample;
  digitizer_pins_t eng_pins;

  // requests while one is pending are dropped: the engine's sample
  // must stay still until it has been copied on this side
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      start_tgl <= 1'b0;
      touch_pending_o <= 1'b0;
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_seen <= 1'b0;
      touch_sample_o <= '0;
      touch_done_o <= 1'b0;
    end
    else
    begin
      done_meta <= done_tgl;
      done_sync <= done_meta;
      done_seen <= done_sync;
      touch_done_o <= done_sync != done_seen;
      if (done_sync != done_seen)
      begin
        touch_sample_o <= eng_sample; // see R09
        touch_pending_o <= 1'b0;
      end
      else if (touch_read_i && !touch_pending_o)
      begin
        start_tgl <= ~start_tgl;
        touch_pending_o <= 1'b1;
      end
    end
  end

  touch_serial_engine u_engine (
    .touch_clk_i(touch_clk_i),
    .arst_n_i(arst_n_i),
    .start_tgl_i(start_tgl),
    .sdo_i(digitizer_sdo_i),
    .pins_o(eng_pins),
    .sample_o(eng_sample),
    .done_tgl_o(done_tgl)
  );

  assign digitizer_cs_n_o = eng_pins.cs_n; // see R10
  assign digitizer_serial_clock_o = eng_pins.sclk;
  assign digitizer_sdi_o = eng_pins.sdi;

endmodule : tft_panel_timing_and_touch_port

// ==== tft_pkg.sv ====
// shared constants and types for the tft panel timing and touch port
package tft_pkg;

  // ---------------------------------------------------------------
  // panel timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_PERIOD_PS = 25000;
  localparam int PANEL_CLK_PERIOD_PS = 25130;
  localparam logic [10:0] LINE_TOTAL = 11'h420;
  localparam logic [10:0] LINE_MIN = 11'h3e8;
  localparam logic [10:0] LINE_ACTIVE_WIDTH = 11'h320;
  localparam logic [9:0] FRAME_ACTIVE_LINES = 10'h258;
  localparam logic [9:0] FRAME_BLANK_LINES = 10'h01c;
  localparam logic [9:0] FRAME_TOTAL_LINES = FRAME_ACTIVE_LINES + FRAME_BLANK_LINES;
  localparam logic [9:0] BLANK_MIN = 10'h00a;
  localparam logic [9:0] BLANK_MAX = 10'h06e;

  // ---------------------------------------------------------------
  // digitizer serial port
  // ---------------------------------------------------------------
  localparam int TOUCH_CLK_PERIOD_PS = 15000;
  localparam int SCLK_MIN_HALF_PS = 250000;
  localparam int SCLK_HALF_CYC_INT =
    (SCLK_MIN_HALF_PS + TOUCH_CLK_PERIOD_PS - 1) / TOUCH_CLK_PERIOD_PS;
  localparam logic [5:0] SCLK_HALF_CYC = 6'(SCLK_HALF_CYC_INT);
  localparam logic [7:0] CMD_READ_X = 8'hd0;
  localparam logic [7:0] CMD_READ_Y = 8'h90;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] DATA_FIRST_BIT = 5'h09;
  localparam logic [4:0] DATA_LAST_BIT = 5'h14;
  localparam logic [4:0] CHAN_LAST_BIT = 5'h17;

  typedef struct packed {
    logic [5:0] red;
    logic [5:0] green;
    logic [5:0] blue;
  } rgb_t;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
  } touch_sample_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } digitizer_pins_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h1,
    ENG_SHIFT = 2'h2
  } eng_state_t;

endpackage : tft_pkg

// ==== tft_port_chk.sv ====
// assertion checker bound to the panel timing and touch port
`timescale 1ns/1ps
module tft_port_chk
  import tft_pkg::*;
(
  input wire logic ref_clk_i, // clock
  input wire logic arst_n_i, // reset
  input rgb_t pixel_colour_i, // colour in
  input wire logic backlight_en_i, // backlight request
  input wire logic pen_down_irq_n_i, // pen pin
  input wire logic pixel_data_enable_o, // enable
  input rgb_t panel_rgb_o, // colour out
  input wire logic backlight_on_o, // backlight
  input wire logic pixel_req_o, // request
  input wire logic pen_event_o // pen pulse
);
  logic [10:0] run;
  logic [16:0] gap;
  logic en_q;
  logic rise;
  assign rise = pixel_data_enable_o && !en_q;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      en_q <= 1'b0;
    else
      en_q <= pixel_data_enable_o;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      run <= 11'h000;
    else
      run <= pixel_data_enable_o ? run + 11'h001 : 11'h000;
  // gap saturates so a long blank never wraps into a legal line length
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      gap <= 17'h00000;
    else if (rise)
      gap <= 17'h00001;
    else if (gap != 17'h00000 && gap != 17'h1ffff)
      gap <= gap + 17'h00001;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence pen_press;
    $fell(pen_down_irq_n_i);
  endsequence
  chk_line_width:
    assert property ($fell(pixel_data_enable_o) |-> run == LINE_ACTIVE_WIDTH)
    else $error("enable width wrong");
  chk_line_period:
    assert property (rise && gap != 17'h00000 && gap < 17'h00800 |-> gap == {6'h00, LINE_TOTAL})
    else $error("line period wrong");
  chk_blank_span:
    assert property (rise && gap >= 17'h00800 |-> gap >= 17'h02d60 && gap <= 17'h1c9e0)
    else $error("blanking length wrong");
  chk_req_enable:
    assert property (pixel_data_enable_o == $past(pixel_req_o))
    else $error("enable not one cycle after request");
  chk_rgb_zero:
    assert property (!pixel_data_enable_o |-> panel_rgb_o == 18'h00000)
    else $error("colour not zero outside enable");
  chk_rgb_pass:
    assert property (pixel_data_enable_o |-> panel_rgb_o == $past(pixel_colour_i))
    else $error("colour not passed through");
  chk_backlight_follow:
    assert property (backlight_on_o == $past(backlight_en_i))
    else $error("backlight does not follow request");
  chk_pen_event:
    assert property (pen_press |-> ##[2:5] pen_event_o)
    else $error("pen event missing");
  chk_pen_cause:
    assert property (pen_event_o |-> !$past(pen_down_irq_n_i, 3))
    else $error("pen event without a press");
endmodule : tft_port_chk
bind tft_panel_timing_and_touch_port tft_port_chk u_port_chk (
  .ref_clk_i, .arst_n_i, .pixel_colour_i, .backlight_en_i, .pen_down_irq_n_i,
  .pixel_data_enable_o, .panel_rgb_o, .backlight_on_o, .pixel_req_o, .pen_event_o
);

// ==== touch_digitizer_model.sv ====
// behavioural touch digitizer answering on the serial port
`timescale 1ns/1ps
module touch_digitizer_model
#(
  parameter logic [11:0] X_VAL = 12'h000,
  parameter logic [11:0] Y_VAL = 12'h000
)
(
  input wire logic cs_n_i, // select, active low
  input wire logic sclk_i, // serial clock
  input wire logic sdi_i, // command bits in
  output logic sdo_o, // data out
  output logic busy_o, // conversion busy
  output logic [15:0] cmd_hist_o // last two commands
);
  logic [4:0] cnt = 5'h00;
  logic [7:0] cmd = 8'h00;
  logic [11:0] val;
  initial
  begin
    sdo_o = 1'b0;
    busy_o = 1'b0;
    cmd_hist_o = 16'h0000;
  end
  // channel bits of the command pick the axis
  assign val = (cmd[6:4] == 3'h5) ? X_VAL : Y_VAL;
  // each channel is 24 clocks under one select, so the count restarts per channel
  always @(posedge sclk_i or posedge cs_n_i)
    if (cs_n_i)
      cnt <= 5'h00;
    else
    begin
      if (cnt < 5'h08)
        cmd <= {cmd[6:0], sdi_i};
      if (cnt == 5'h07)
        cmd_hist_o <= {cmd_hist_o[7:0], cmd[6:0], sdi_i};
      cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
    end
  // a released line must not keep its last level
  always @(negedge sclk_i or posedge cs_n_i)
    if (cs_n_i)
      sdo_o <= ~sdo_o;
    else
    begin
      busy_o <= (cnt == 5'h08);
      sdo_o <= (cnt >= 5'h09 && cnt <= 5'h14) ? val[5'h14 - cnt] : ~sdo_o;
    end
endmodule : touch_digitizer_model

// ==== touch_serial_engine.sv ====
// digitizer serial engine running on the touch link clock
`timescale 1ns/1ps
module touch_serial_engine
  import tft_pkg::*;
(
  input wire logic touch_clk_i, // link clock of the serial port
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic start_tgl_i, // toggles once per read request (other domain)
  input wire logic sdo_i, // serial data out from digitizer (pin)
  output digitizer_pins_t pins_o, // chip select, serial clock, serial data in
  output touch_sample_t sample_o, // x and y, stable after done toggles
  output logic done_tgl_o // toggles once per finished read
);

  // ---------------------------------------------------------------
  // crossings into the link domain
  // ---------------------------------------------------------------
  logic start_meta;
  logic start_sync;
  logic start_seen;
  logic sdo_meta;
  logic sdo_sync;

  always_ff @(posedge touch_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_seen <= 1'b0;
      sdo_meta <= 1'b0;
      sdo_sync <= 1'b0;
    end
    else
    begin
      start_meta <= start_tgl_i;
      start_sync <= start_meta;
      start_seen <= start_sync;
      sdo_meta <= sdo_i;
      sdo_sync <= sdo_meta;
    end
  end

  // ---------------------------------------------------------------
  // shift sequencer: x channel then y channel, 24 serial clocks each
  // ---------------------------------------------------------------
  eng_state_t state;
  logic [5:0] half_cnt;
  logic [4:0] bit_idx;
  logic chan_y;
  logic [11:0] shift_in;
  logic [7:0] cmd;
  logic half_end;
  logic [4:0] cmd_pos;

  assign half_end = (half_cnt == SCLK_HALF_CYC - 6'h01);
  assign cmd = chan_y ? CMD_READ_Y : CMD_READ_X;

  always_comb
  begin
    cmd_pos = CMD_BITS - 5'h01 - bit_idx;
  end

  always_ff @(posedge touch_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= ENG_IDLE;
      half_cnt <= 6'h00;
      bit_idx <= 5'h00;
      chan_y <= 1'b0;
      shift_in <= 12'h000;
      pins_o <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
      sample_o <= '0;
      done_tgl_o <= 1'b0;
    end
    else
    begin
      case (state)
        ENG_IDLE:
        begin
          half_cnt <= 6'h00;
          if (start_sync != start_seen)
          begin
            state <= ENG_SHIFT;
            bit_idx <= 5'h00;
            chan_y <= 1'b0;
            pins_o.cs_n <= 1'b0; // see R10
            pins_o.sdi <= CMD_READ_X[7];
          end
        end
        ENG_SHIFT:
        begin
          half_cnt <= half_end ? 6'h00 : half_cnt + 6'h01;
          if (half_end)
          begin
            pins_o.sclk <= ~pins_o.sclk; // see R10
            if (pins_o.sclk)
            begin
              // falling edge: data bit is settled, next command bit goes out
              if (bit_idx >= DATA_FIRST_BIT && bit_idx <= DATA_LAST_BIT)
                shift_in <= {shift_in[10:0], sdo_sync}; // see R09
              if (bit_idx == CHAN_LAST_BIT)
              begin
                bit_idx <= 5'h00;
                if (chan_y)
                begin
                  state <= ENG_IDLE;
                  pins_o.cs_n <= 1'b1;
                  pins_o.sdi <= 1'b0;
                  sample_o.y <= shift_in;
                  done_tgl_o <= ~done_tgl_o;
                end
                else
                begin
                  chan_y <= 1'b1;
                  sample_o.x <= shift_in;
                  pins_o.sdi <= CMD_READ_Y[7];
                end
              end
              else
              begin
                bit_idx <= bit_idx + 5'h01;
                pins_o.sdi <= (bit_idx + 5'h01 < CMD_BITS) ?
                  cmd[3'(cmd_pos - 5'h01)] : 1'b0;
              end
            end
          end
        end
        default:
        begin
          state <= ENG_IDLE;
        end
      endcase
    end
  end

endmodule : touch_serial_engine
